// [power_saving_mode_control_tb.sv]
// Testbench for the power-saving mode controller
`timescale 1ns/1ps
module power_saving_mode_control_tb;
  // ==========================================
  // Stimulus and observed signals
  logic hclk, hresetn, hsel, hwrite, hready, irq_en, ack, hreadyout, hresp;
  logic [7:0]  haddr;
  logic [1:0]  htrans, mode;
  logic [2:0]  src;
  logic [31:0] hwdata, hrdata, q;
  logic c, p, o, pc, ic, ph, dh, doe, sf, sl, wk;
  int bad_count, compares, cyc;
  wire logic [10:0] outs = {c, p, o, pc, ic, ph, doe, sf, wk, mode};
  assign hready = hreadyout;
  psm_ctrl i_psm_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq_enabled(irq_en),
    .tic_irq(src[0]), .serial_irq(src[1]), .ext_irq_zero(src[2]), .core_ret_ack(ack),
    .core_clk_en(c), .pll_en(p), .osc_en(o), .periph_clk_en(pc),
    .interval_counter_en(ic), .pin_hold(ph), .dac_hold(dh), .dac_oe(doe),
    .strobe_force(sf), .strobe_level(sl), .wake_irq_req(wk), .mode(mode));
  psm_core_model i_psm_core_model (.hclk(hclk), .hresetn(hresetn), .wake_irq_req(wk),
    .core_ret_ack(ack));
  // ==========================================
  // Clock and hang guard
  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      print_verdict();
    end
  end
  // ==========================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t: saw %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : tick
  // One AHB-Lite single word; read data taken in the data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'h1;
    haddr  <= a;
    hwrite <= w;
    htrans <= psm_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic print_verdict();
    $display("Mismatches %0d, comparisons %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  // ==========================================
  // Main sequence
  initial
  begin
    {hresetn, hsel, hwrite, irq_en, src, haddr, htrans, hwdata} = '0;
    tick(8);
    hresetn <= 1'b1;
    bus(0, psm_pkg::PWR_CTRL_OFS, 0); chk(q, 0);
    chk(outs, 11'h7D0);
    bus(1, psm_pkg::PWR_CTRL_OFS, 32'h1); tick(1);
    chk(outs, 11'h3F9);
    chk({sl, dh}, 2'h3);
    irq_en <= 1'b1; tick(2); chk(outs, 11'h7D0);
    irq_en <= 1'b0;
    bus(1, psm_pkg::PWR_CTRL_OFS, 32'h2); tick(1);
    chk(outs, 11'h16B);
    chk(sl, 1'b0);
    bus(0, psm_pkg::STATUS_OFS, 0); chk(q, 32'h3);
    src <= 3'h6; tick(3); chk(outs, 11'h16B);
    src <= 3'h1; tick(2); chk(outs, 11'h7D4);
    src <= 3'h0; tick(8); chk(outs, 11'h7D0);
    bus(1, psm_pkg::PLL_CTRL_OFS, 32'h1);
    for (int k = 1; k < 3; k++)
    begin
      bus(1, psm_pkg::PWR_CTRL_OFS, 32'h2 | (32'h2 << k)); tick(1);
      chk(outs, 11'h02B);
      src <= 3'h1 << k; tick(2); chk(outs, 11'h7D4);
      src <= 3'h0; tick(8); chk(outs, 11'h7D0);
    end
    bus(1, psm_pkg::PWR_CTRL_OFS, 32'h2); tick(1);
    hresetn <= 1'b0; tick(2);
    hresetn <= 1'b1; tick(1); chk(outs, 11'h7D0);
    bus(0, psm_pkg::PLL_CTRL_OFS, 0); chk(q, 0);
    print_verdict();
  end
endmodule : power_saving_mode_control_tb

// [psm_core_model.sv]
// Behavioural core that services the power-down wake interrupt
`timescale 1ns/1ps
module psm_core_model #(
  parameter int ACK_DLY = 4
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic wake_irq_req,
  output logic      core_ret_ack
);
  // ==========================================
  // Service delay
  // The return pulse comes late, so the request must stand meanwhile
  int cnt;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt          <= 0;
      core_ret_ack <= 1'b0;
    end
    else if (wake_irq_req && cnt < ACK_DLY)
    begin
      cnt          <= cnt + 1;
      core_ret_ack <= (cnt == ACK_DLY - 1);
    end
    else
    begin
      cnt          <= 0;
      core_ret_ack <= 1'b0;
    end
  end
endmodule : psm_core_model

// [psm_ctrl.sv]
// Power-saving mode controller with AHB-Lite register slave
//
// The implementer's own choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
module psm_ctrl (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        irq_enabled,
  input  wire logic        tic_irq,
  input  wire logic        serial_irq,
  input  wire logic        ext_irq_zero,
  input  wire logic        core_ret_ack,
  output logic             core_clk_en,
  output logic             pll_en,
  output logic             osc_en,
  output logic             periph_clk_en,
  output logic             interval_counter_en,
  output logic             pin_hold,
  output logic             dac_hold,
  output logic             dac_oe,
  output logic             strobe_force,
  output logic             strobe_level,
  output logic             wake_irq_req,
  output logic [1:0]       mode
);

  // ==========================================================
  // Bus address phase capture
  logic       wr_pend_r;
  logic [7:0] addr_r;
  wire        take = hsel && hready && (htrans == psm_pkg::HTRANS_NONSEQ);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      addr_r    <= 8'h00;
    end
    else
    begin
      wr_pend_r <= take && hwrite;
      if (take)
        addr_r  <= haddr;
    end
  end

  // ==========================================================
  // Registers
  logic [psm_pkg::CTRL_W-1:0] power_control_reg;
  logic [psm_pkg::PLL_W-1:0]  pll_control_reg;
  psm_pkg::psm_state_t        state_r;
  psm_pkg::psm_state_t        state_nxt;

  wire wr_ctrl = wr_pend_r && (addr_r == psm_pkg::PWR_CTRL_OFS);
  wire wr_pll  = wr_pend_r && (addr_r == psm_pkg::PLL_CTRL_OFS);
  wire serial_wake_enable       = power_control_reg[psm_pkg::SER_WK_BIT];
  wire ext_irq_zero_wake_enable = power_control_reg[psm_pkg::EXT_IRQ_ZERO_WK_BIT];
  wire oscillator_powerdown_bit = pll_control_reg[psm_pkg::OSCILLATOR_POWERDOWN_BIT_BIT];

  // Qualified wake sources; a disabled source is simply not seen
  wire pd_wake = tic_irq
               || (serial_irq && serial_wake_enable)
               || (ext_irq_zero && ext_irq_zero_wake_enable);
  wire idle_wake = irq_enabled;

  // Mode bits self-clear on exit so the core resumes with both at zero
  wire leaving = ((state_r == psm_pkg::PSM_IDLE) && idle_wake)
               || ((state_r == psm_pkg::PSM_PDOWN) && pd_wake);

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      psm_pkg::PSM_NORMAL:
      begin
        if (power_control_reg[psm_pkg::PDOWN_BIT])
          state_nxt = psm_pkg::PSM_PDOWN;
        else if (power_control_reg[psm_pkg::IDLE_BIT])
          state_nxt = psm_pkg::PSM_IDLE;
      end
      psm_pkg::PSM_IDLE:
        if (idle_wake)
          state_nxt = psm_pkg::PSM_NORMAL;
      psm_pkg::PSM_PDOWN:
        if (pd_wake)
          state_nxt = psm_pkg::PSM_NORMAL;
      default:
        state_nxt = psm_pkg::PSM_NORMAL;
    endcase
  end

  // Register writes; reset returns everything to default
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      power_control_reg <= psm_pkg::CTRL_RST;
      pll_control_reg   <= psm_pkg::PLL_RST;
      state_r           <= psm_pkg::PSM_NORMAL;
    end
    else
    begin
      state_r <= state_nxt;
      if (leaving)
        power_control_reg[psm_pkg::PDOWN_BIT:psm_pkg::IDLE_BIT] <= 2'h0;
      else if (wr_ctrl)
        power_control_reg <= hwdata[psm_pkg::CTRL_W-1:0];
      if (wr_pll)
        pll_control_reg <= hwdata[psm_pkg::PLL_W-1:0];
    end
  end

  // ==========================================================
  // Read data and response
  wire [31:0] rd_mux =
    (addr_r == psm_pkg::PWR_CTRL_OFS) ? {28'h0, power_control_reg} :
    (addr_r == psm_pkg::PLL_CTRL_OFS) ? {31'h0, pll_control_reg} :
    (addr_r == psm_pkg::STATUS_OFS)   ? {30'h0, state_r} : 32'h0;
  assign hrdata    = rd_mux;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ==========================================================
  // Clock and pin controls, registered from the next state
  wire nx_idle = (state_nxt == psm_pkg::PSM_IDLE);
  wire nx_pd   = (state_nxt == psm_pkg::PSM_PDOWN);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      core_clk_en         <= 1'b1;
      pll_en              <= 1'b1;
      osc_en              <= 1'b1;
      periph_clk_en       <= 1'b1;
      interval_counter_en <= 1'b1;
      pin_hold            <= 1'b0;
      dac_hold            <= 1'b0;
      dac_oe              <= 1'b1;
      strobe_force        <= 1'b0;
      strobe_level        <= 1'b0;
      wake_irq_req        <= 1'b0;
      mode                <= 2'h0;
    end
    else
    begin
      core_clk_en         <= !(nx_idle || nx_pd);
      pll_en              <= !nx_pd;
      osc_en              <= !(nx_pd && oscillator_powerdown_bit);
      periph_clk_en       <= !nx_pd;
      interval_counter_en <= !(nx_pd && oscillator_powerdown_bit);
      pin_hold            <= nx_idle || nx_pd;
      dac_hold            <= nx_idle;
      dac_oe              <= !nx_pd;
      strobe_force        <= nx_idle || nx_pd;
      strobe_level        <= nx_idle;
      wake_irq_req        <= (state_r == psm_pkg::PSM_PDOWN) && pd_wake
                             || (wake_irq_req && !core_ret_ack);
      mode                <= state_nxt;
    end
  end

  // ==========================================================
  // Checks
  chk_pd_strobe: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == psm_pkg::PSM_PDOWN && !pd_wake) |=> (strobe_force && !strobe_level && !dac_oe))
    else $error("power-down pins wrong");
  chk_idle_strobe: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == psm_pkg::PSM_IDLE && !idle_wake) |=> (strobe_level && !core_clk_en))
    else $error("idle pins wrong");
  chk_ser_ignore: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == psm_pkg::PSM_PDOWN && !tic_irq && !ext_irq_zero && serial_irq
     && !serial_wake_enable) |=> (state_r == psm_pkg::PSM_PDOWN))
    else $error("disabled serial wake left power-down");
  chk_tic_wake: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == psm_pkg::PSM_PDOWN && tic_irq) |=> (state_r == psm_pkg::PSM_NORMAL
     && wake_irq_req))
    else $error("interval wake missed");
  chk_oscillator_powerdown_bit: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == psm_pkg::PSM_PDOWN) |=> (osc_en != $past(oscillator_powerdown_bit)
     || $past(pd_wake)))
    else $error("oscillator control wrong");
  chk_pll_off: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == psm_pkg::PSM_PDOWN && !pd_wake) |=> (!pll_en && !periph_clk_en))
    else $error("pll running in power-down");
  chk_idle_wake: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == psm_pkg::PSM_IDLE && irq_enabled) |=> ##1 core_clk_en)
    else $error("idle wake missed");
  chk_enter_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == psm_pkg::PSM_NORMAL && power_control_reg == 4'h1) |=> (mode == 2'h1))
    else $error("idle entry missed");

  // ==========================================================
  // State-to-pin checks; outputs are registered from the same next state as state_r
  // Mode output mirrors the state register at every edge
  chk_mode_track: assert property (
    @(posedge hclk) disable iff (!hresetn)
    mode == state_r)
    else $error("mode output differs from state");

  // Normal mode runs every clock
  chk_norm_clocks: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_r == psm_pkg::PSM_NORMAL) |-> (core_clk_en && pll_en && periph_clk_en))
    else $error("clock stopped in normal mode");

  // Normal mode releases every pin override
  chk_norm_pins: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_r == psm_pkg::PSM_NORMAL) |-> (!pin_hold && !dac_hold && dac_oe && !strobe_force))
    else $error("pin override left in normal mode");

  // Idle keeps the oscillator, PLL and peripheral clock alive
  chk_idle_osc: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_r == psm_pkg::PSM_IDLE) |-> (osc_en && pll_en && periph_clk_en))
    else $error("idle stopped a running clock");

  // Idle halts only the core, so its state is kept rather than reset
  chk_idle_core: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_r == psm_pkg::PSM_IDLE) |-> !core_clk_en)
    else $error("core clock running in idle");

  // Idle freezes pins and DAC and forces strobes
  chk_idle_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_r == psm_pkg::PSM_IDLE) |-> (pin_hold && dac_hold && dac_oe && strobe_force))
    else $error("idle pin hold wrong");

  // Power-down stops core and PLL
  chk_pd_core: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_r == psm_pkg::PSM_PDOWN) |-> (!core_clk_en && !pll_en))
    else $error("core or pll running in power-down");

  // Power-down shuts the ordinary peripherals
  chk_pd_periph: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_r == psm_pkg::PSM_PDOWN) |-> !periph_clk_en)
    else $error("peripherals clocked in power-down");

  // Power-down holds pins but lets the DAC float instead of holding it
  chk_pd_pins: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_r == psm_pkg::PSM_PDOWN) |-> (pin_hold && !dac_hold))
    else $error("power-down pin hold wrong");

  // Power-down floats the DAC and drives strobes low
  chk_pd_dac: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_r == psm_pkg::PSM_PDOWN) |-> (!dac_oe && !strobe_level))
    else $error("power-down dac or strobe wrong");

  // Oscillator kept on: interval counter stays alive
  chk_pd_tic_run: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_r == psm_pkg::PSM_PDOWN && !oscillator_powerdown_bit && !pd_wake)
    |=> (osc_en && interval_counter_en))
    else $error("oscillator stopped while kept on");

  // Oscillator powered down: counter loses its clock too
  chk_pd_osc_off: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_r == psm_pkg::PSM_PDOWN && oscillator_powerdown_bit && !pd_wake)
    |=> (!osc_en && !interval_counter_en))
    else $error("oscillator running while powered down");

  // Disabled interrupt-zero wake is ignored
  chk_ext_ignore: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_r == psm_pkg::PSM_PDOWN && !tic_irq && !serial_irq && ext_irq_zero
     && !ext_irq_zero_wake_enable) |=> (state_r == psm_pkg::PSM_PDOWN))
    else $error("disabled interrupt-zero wake left power-down");

  // Enabled serial wake ends power-down and raises the request
  chk_ser_wake: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_r == psm_pkg::PSM_PDOWN && serial_irq && serial_wake_enable)
    |=> (state_r == psm_pkg::PSM_NORMAL && wake_irq_req))
    else $error("serial wake missed");

  // Enabled interrupt-zero wake ends power-down and raises the request
  chk_ext_wake: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_r == psm_pkg::PSM_PDOWN && ext_irq_zero && ext_irq_zero_wake_enable)
    |=> (state_r == psm_pkg::PSM_NORMAL && wake_irq_req))
    else $error("interrupt-zero wake missed");

  // Mode bits clear on wake, so the core does not fall straight back asleep
  chk_pd_bits_clear: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_r == psm_pkg::PSM_PDOWN && pd_wake)
    |=> (!power_control_reg[psm_pkg::PDOWN_BIT] && !power_control_reg[psm_pkg::IDLE_BIT]))
    else $error("mode bits kept after wake");

  // Wake request stands until the core takes it
  chk_wake_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wake_irq_req && !core_ret_ack) |=> wake_irq_req)
    else $error("wake request dropped early");

  // Core return clears the wake request
  chk_wake_clear: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wake_irq_req && core_ret_ack && !(state_r == psm_pkg::PSM_PDOWN && pd_wake))
    |=> !wake_irq_req)
    else $error("wake request not cleared");

  // Without a qualified wake, power-down persists
  chk_pd_stay: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_r == psm_pkg::PSM_PDOWN && !pd_wake) |=> (state_r == psm_pkg::PSM_PDOWN))
    else $error("power-down left without wake");

  // Power-down bit wins over the idle bit
  chk_pd_entry: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_r == psm_pkg::PSM_NORMAL && power_control_reg[psm_pkg::PDOWN_BIT])
    |=> (state_r == psm_pkg::PSM_PDOWN))
    else $error("power-down entry missed");

  // Idle persists until an enabled interrupt
  chk_idle_stay: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_r == psm_pkg::PSM_IDLE && !idle_wake) |=> (state_r == psm_pkg::PSM_IDLE))
    else $error("idle left without interrupt");

endmodule : psm_ctrl

// [psm_pkg.sv]
// Constants, register map and state encoding for the power-saving mode controller
package psm_pkg;
  // Register byte offsets
  localparam logic [7:0] PWR_CTRL_OFS = 8'h00;
  localparam logic [7:0] PLL_CTRL_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS   = 8'h08;
  // Power control fields
  localparam int IDLE_BIT    = 0;
  localparam int PDOWN_BIT   = 1;
  localparam int SER_WK_BIT  = 2;
  localparam int EXT_IRQ_ZERO_WK_BIT = 3;
  localparam int CTRL_W      = 4;
  // PLL control fields
  localparam int OSCILLATOR_POWERDOWN_BIT_BIT  = 0;
  localparam int PLL_W       = 1;
  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
  localparam logic [PLL_W-1:0]  PLL_RST  = 1'h0;
  localparam logic [1:0]        HTRANS_NONSEQ = 2'h2;
  // Mode states, Gray coded
  typedef enum logic [1:0] {
    PSM_NORMAL = 2'h0,
    PSM_IDLE   = 2'h1,
    PSM_PDOWN  = 2'h3
  } psm_state_t;
endpackage : psm_pkg
